/* shared/dcf_pkg.sv */
// Shared constants and types for the programmable-flag FIFO.
// Operation
// - Reset empties the FIFO, drives empty flag low, returns both pointers.
// - After reset, data outputs read low while output enable is asserted.
// - Array holds 8K to 64K words of 18 bits, independent pointers.
// - Write enable low with load high stores input data each edge.
// - Read enable low presents the next stored word each edge.
// - Output enable high tri-states outputs; low drives the output register.
// - In a cascade only the device holding the read token drives outputs.
// - Writes ignored when full, reads ignored when empty, last word held.
// - Two 16-bit offset registers loaded from data bits 0 to 15.
// - Unprogrammed offset registers use default threshold values.
// - Load and write enable low: first edge writes the empty offset.
// - Second such edge writes full offset, third wraps to empty offset.
// - Offset sequence position survives load going high; next write continues.
// - Load and read enable low: edges read offsets in the same order.
// - Full flag low when full; writes blocked whatever write enable says.
// - Full flag updated on write edges, empty flag on read edges.
// - Empty flag low when empty; reads blocked whatever read enable says.
// - Almost-empty low up to n words; half-full low above half depth.
// - Almost-full low from depth minus full offset words upward.
// - Sync mode: almost flags change only on their own port's edges.
// - Close read/write edges may delay sync almost-full by one write edge.
// - Flags follow pointers during replay; sync almost flags need one more edge.
// - Replay pulse returns read pointer to first location, replays stored data.
package dcf_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int DEPTH_LOG2_DEF = 13;
  localparam int WORD_W = 18;
  localparam int OFS_W = 16;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] EMPTY_OFS_RST = 16'h007F;
  localparam logic [15:0] FULL_OFS_RST = 16'h007F;
  localparam logic [17:0] DATA_OUT_RST = 18'h00000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {
    DCF_SEL_EMPTY = 1'b0,
    DCF_SEL_FULL = 1'b1
  } dcf_sel_t;

  // cascade token: wait for strap, hold, passed on
  typedef enum logic [1:0] {
    DCF_TOK_WAIT = 2'b00,
    DCF_TOK_HOLD = 2'b01,
    DCF_TOK_PASSED = 2'b11
  } dcf_tok_t;

endpackage

/* rtl/dcf_mem.sv */
// Storage array with a registered read port.
`timescale 1ns/1ps
module dcf_mem #(
  parameter int AW = 13,
  parameter int DW = 18
) (
  // clock
  input wire logic clock,
  // write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  // read port
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);

  logic [DW-1:0] cells [0:(1<<AW)-1];

  // no reset on the array: contents are undefined until written
  always_ff @(posedge clock) begin
    if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
    if (rdEn) begin
      rdData <= cells[rdAddr];
    end
  end

endmodule

/* rtl/dcf_fifo.sv */
// FIFO with programmable almost flags, replay and cascade token.
`timescale 1ns/1ps
module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int AW = DEPTH_LOG2_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // write side
  input wire logic writeEn_n,
  input wire logic [17:0] dataIn,
  input wire logic offset_load_n,
  // read side
  input wire logic readEn_n,
  input wire logic outEnable_n,
  input wire logic replay_pulse,
  output logic [17:0] dataOut,
  output logic dataOutEn,
  // flags
  input wire logic sync_flag_mode,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic half_full_flag_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n,
  // depth expansion
  input wire logic depthExpand,
  input wire logic first_load_n,
  input wire logic write_cascade_in,
  input wire logic read_cascade_in,
  output logic write_cascade_out,
  output logic read_cascade_out
);

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int DEPTH = 1 << AW;
  localparam int HALF = DEPTH / 2;
  localparam logic [AW:0] PTR_ONE = (AW+1)'(1);

  function automatic logic [AW:0] wordCount(input logic [AW:0] w,
                                            input logic [AW:0] r);
    return w - r;
  endfunction

  logic [AW:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
  logic [15:0] emptyOfs, next_emptyOfs, fullOfs, next_fullOfs;
  dcf_sel_t wrSel, next_wrSel, rdSel, next_rdSel;
  dcf_tok_t wrTok, next_wrTok, rdTok, next_rdTok;
  logic next_write_cascade_out, next_read_cascade_out;
  logic [17:0] next_dataOut, memQ;
  logic next_dataOutEn, readPend, next_readPend;
  logic next_empty, next_full, next_half, next_ae, next_af;
  logic [AW:0] curCount, nxtCount, aeCount, afCount;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic wrOwn, rdOwn, progWrite, storeWrite, progRead, fetch;
  assign wrOwn = !depthExpand || wrTok == DCF_TOK_HOLD;
  assign rdOwn = !depthExpand || rdTok == DCF_TOK_HOLD;
  assign progWrite = !writeEn_n && !offset_load_n;
  // full flag gates writes regardless of enable
  assign storeWrite = !writeEn_n && offset_load_n && full_flag_n
                      && wrOwn;
  assign progRead = !readEn_n && !offset_load_n;
  assign fetch = !readEn_n && offset_load_n && empty_flag_n && rdOwn
                 && !replay_pulse;

  dcf_mem #(
    .AW(AW),
    .DW(WORD_W)
  ) u_mem (
    .clock(clock),
    .wrEn(storeWrite),
    .wrAddr(wrPtr[AW-1:0]),
    .wrData(dataIn),
    .rdEn(fetch),
    .rdAddr(rdPtr[AW-1:0]),
    .rdData(memQ)
  );

  // ----------------------------------------------------------------
  // write side and offset programming
  // ----------------------------------------------------------------
  always_comb begin
    next_wrPtr = wrPtr;
    next_emptyOfs = emptyOfs;
    next_fullOfs = fullOfs;
    next_wrSel = wrSel;
    next_wrTok = wrTok;
    next_write_cascade_out = 1'b1;
    if (progWrite) begin
      if (wrSel == DCF_SEL_EMPTY) begin
        next_emptyOfs = dataIn[OFS_W-1:0];
        next_wrSel = DCF_SEL_FULL;
      end else begin
        next_fullOfs = dataIn[OFS_W-1:0];
        next_wrSel = DCF_SEL_EMPTY;
      end
    end
    if (storeWrite) begin
      next_wrPtr = wrPtr + PTR_ONE;
    end
    case (wrTok)
      // strap sampled on the first edge after reset release
      DCF_TOK_WAIT: begin
        next_wrTok = first_load_n ? DCF_TOK_PASSED : DCF_TOK_HOLD;
      end
      DCF_TOK_HOLD: begin
        if (depthExpand && storeWrite && &wrPtr[AW-1:0]) begin
          next_wrTok = DCF_TOK_PASSED;
          next_write_cascade_out = 1'b0;
        end
      end
      DCF_TOK_PASSED: begin
        if (!write_cascade_in) begin
          next_wrTok = DCF_TOK_HOLD;
        end
      end
      default: begin
        next_wrTok = DCF_TOK_WAIT;
      end
    endcase
  end

  // selector is only cleared by reset, so a paused sequence resumes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= '0;
      emptyOfs <= EMPTY_OFS_RST;
      fullOfs <= FULL_OFS_RST;
      wrSel <= DCF_SEL_EMPTY;
      wrTok <= DCF_TOK_WAIT;
      write_cascade_out <= 1'b1;
    end else begin
      wrPtr <= next_wrPtr;
      emptyOfs <= next_emptyOfs;
      fullOfs <= next_fullOfs;
      wrSel <= next_wrSel;
      wrTok <= next_wrTok;
      write_cascade_out <= next_write_cascade_out;
    end
  end

  // ----------------------------------------------------------------
  // read side, replay and output register
  // ----------------------------------------------------------------
  always_comb begin
    next_rdPtr = rdPtr;
    next_rdSel = rdSel;
    next_rdTok = rdTok;
    next_read_cascade_out = 1'b1;
    next_readPend = fetch;
    next_dataOut = dataOut;
    // output drives only when enabled and this device owns the read
    next_dataOutEn = !outEnable_n && rdOwn;
    if (replay_pulse) begin
      // a full wrap of writes replays the whole array
      next_rdPtr = {(wrPtr[AW-1:0] == '0) ? ~wrPtr[AW] : wrPtr[AW],
                    {AW{1'b0}}};
    end else if (fetch) begin
      next_rdPtr = rdPtr + PTR_ONE;
    end
    if (readPend) begin
      next_dataOut = memQ;
    end else if (progRead) begin
      next_dataOut = {2'b00, (rdSel == DCF_SEL_EMPTY) ? emptyOfs
                                                       : fullOfs};
      next_rdSel = (rdSel == DCF_SEL_EMPTY) ? DCF_SEL_FULL
                                            : DCF_SEL_EMPTY;
    end
    case (rdTok)
      DCF_TOK_WAIT: begin
        next_rdTok = first_load_n ? DCF_TOK_PASSED : DCF_TOK_HOLD;
      end
      DCF_TOK_HOLD: begin
        if (depthExpand && fetch && &rdPtr[AW-1:0]) begin
          next_rdTok = DCF_TOK_PASSED;
          next_read_cascade_out = 1'b0;
        end
      end
      DCF_TOK_PASSED: begin
        if (!read_cascade_in) begin
          next_rdTok = DCF_TOK_HOLD;
        end
      end
      default: begin
        next_rdTok = DCF_TOK_WAIT;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdPtr <= '0;
      rdSel <= DCF_SEL_EMPTY;
      rdTok <= DCF_TOK_WAIT;
      read_cascade_out <= 1'b1;
      readPend <= 1'b0;
      dataOut <= DATA_OUT_RST;
      dataOutEn <= 1'b0;
    end else begin
      rdPtr <= next_rdPtr;
      rdSel <= next_rdSel;
      rdTok <= next_rdTok;
      read_cascade_out <= next_read_cascade_out;
      readPend <= next_readPend;
      dataOut <= next_dataOut;
      dataOutEn <= next_dataOutEn;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  assign curCount = wordCount(wrPtr, rdPtr);
  assign nxtCount = wordCount(next_wrPtr, next_rdPtr);
  // with sync_flag_mode low the almost flags lag one edge behind the pointers,
  // trading latency for a flag that never moves between edges
  assign aeCount = sync_flag_mode ? nxtCount : curCount;
  assign afCount = sync_flag_mode ? nxtCount : curCount;

  always_comb begin
    next_empty = nxtCount != '0;
    next_full = int'(nxtCount) != DEPTH;
    next_half = !(int'(nxtCount) > HALF);
    next_ae = int'(aeCount) > int'(emptyOfs);
    next_af = !(int'(afCount) >= DEPTH - int'(fullOfs));
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      empty_flag_n <= 1'b0;
      full_flag_n <= 1'b1;
      half_full_flag_n <= 1'b1;
      almost_empty_flag_n <= 1'b0;
      almost_full_flag_n <= 1'b1;
    end else begin
      empty_flag_n <= next_empty;
      full_flag_n <= next_full;
      half_full_flag_n <= next_half;
      almost_empty_flag_n <= next_ae;
      almost_full_flag_n <= next_af;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dcfCk @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  a_full_blocks_write: assert property (
    !full_flag_n |=> $stable(wrPtr) || $past(!full_flag_n) == 1'b0)
    else $error("write accepted while full");

  a_empty_blocks_read: assert property (
    !empty_flag_n && !replay_pulse |=> rdPtr == $past(rdPtr))
    else $error("read pointer moved while empty");

  a_store_advances: assert property (
    !writeEn_n && offset_load_n && full_flag_n && wrOwn
    |=> wrPtr == $past(wrPtr) + PTR_ONE)
    else $error("store did not advance write pointer");

  a_empty_flag_count: assert property (
    empty_flag_n == (wrPtr != rdPtr))
    else $error("empty flag disagrees with pointers");

  a_full_flag_count: assert property (
    full_flag_n == (int'(curCount) != DEPTH))
    else $error("full flag disagrees with count");

  a_half_flag_count: assert property (
    half_full_flag_n == !(int'(curCount) > HALF))
    else $error("half-full flag wrong");

  a_almost_empty_sync: assert property (
    !sync_flag_mode && $past(!sync_flag_mode) && $stable(emptyOfs)
    |-> almost_empty_flag_n == ($past(int'(curCount)) > int'(emptyOfs)))
    else $error("sync almost-empty flag wrong");

  a_almost_full_async: assert property (
    sync_flag_mode && $stable(fullOfs)
    |-> almost_full_flag_n == !(int'(curCount) >= DEPTH - int'(fullOfs)))
    else $error("almost-full flag wrong");

  a_prog_sequence: assert property (
    !writeEn_n && !offset_load_n |=> wrSel != $past(wrSel))
    else $error("offset selector did not advance");

  a_output_tristate: assert property (
    outEnable_n |=> !dataOutEn)
    else $error("outputs driven with enable high");

  a_replay_pointer: assert property (
    replay_pulse |=> rdPtr[AW-1:0] == '0)
    else $error("replay did not rewind read pointer");

endmodule

/* tb/dcf_partner.sv */
// Writer and reader logic on the far side of the FIFO.
`timescale 1ns/1ps
module dcf_partner (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // writer
  output logic writeEn_n,
  output logic [17:0] dataIn,
  output logic offset_load_n,
  // reader
  output logic readEn_n
);
  int waitFails = 0;

  initial begin
    writeEn_n = 1'b1;
    readEn_n = 1'b1;
    offset_load_n = 1'b1;
    dataIn = 18'h00000;
  end

  // n back-to-back write edges from d upward; ldN low hits offsets
  // bounded: a reset that never lifts is counted, not waited out
  task automatic hold_off();
    for (int i = 0; i < 64 && !arst_n; i++) begin
      @(posedge clock);
      #1;
    end
    if (!arst_n) begin
      waitFails++;
      $display("mismatch at %0t: reset never released", $time);
    end
  endtask

  task automatic put(input logic [17:0] d, input int n, input logic ldN);
    hold_off();
    writeEn_n = 1'b0;
    offset_load_n = ldN;
    for (int i = 0; i < n; i++) begin
      dataIn = d + 18'(i);
      @(posedge clock);
      #1;
    end
    writeEn_n = 1'b1;
    offset_load_n = 1'b1;
    // released bus must not look like a held word
    dataIn = ~dataIn;
  endtask

  // n back-to-back read edges with the enable held low throughout
  task automatic drain(input int n);
    hold_off();
    readEn_n = 1'b0;
    offset_load_n = 1'b1;
    repeat (n) begin
      @(posedge clock);
      #1;
    end
    readEn_n = 1'b1;
  endtask

  task automatic get(input logic ldN);
    hold_off();
    readEn_n = 1'b0;
    offset_load_n = ldN;
    @(posedge clock);
    #1;
    readEn_n = 1'b1;
    offset_load_n = 1'b1;
  endtask
endmodule

/* tb/dcf_fifo_tb_top.sv */
// Self-checking bench for the programmable-flag FIFO.
`timescale 1ns/1ps
module dcf_fifo_tb_top;
  localparam int DEPTH = 8192;
  localparam int HALF = DEPTH / 2;
  logic clock;
  logic arst_n;
  logic writeEn_n;
  logic [17:0] dataIn;
  logic offset_load_n;
  logic readEn_n;
  logic outEnable_n;
  logic replay_pulse;
  logic [17:0] dataOut;
  logic dataOutEn;
  logic sync_flag_mode;
  logic empty_flag_n;
  logic full_flag_n;
  logic half_full_flag_n;
  logic almost_empty_flag_n;
  logic almost_full_flag_n;
  logic depthExpand;
  logic first_load_n;
  logic write_cascade_in;
  logic read_cascade_in;
  logic write_cascade_out;
  logic read_cascade_out;
  logic [4:0] flags;
  int fail_count = 0;
  int checked = 0;

  assign flags = {empty_flag_n, full_flag_n, half_full_flag_n,
                  almost_empty_flag_n, almost_full_flag_n};

  dcf_fifo #(.AW(13)) dut (.clock(clock), .arst_n(arst_n),
    .writeEn_n(writeEn_n), .dataIn(dataIn), .offset_load_n(offset_load_n),
    .readEn_n(readEn_n), .outEnable_n(outEnable_n),
    .replay_pulse(replay_pulse), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .sync_flag_mode(sync_flag_mode), .empty_flag_n(empty_flag_n),
    .full_flag_n(full_flag_n), .half_full_flag_n(half_full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n),
    .almost_full_flag_n(almost_full_flag_n), .depthExpand(depthExpand),
    .first_load_n(first_load_n), .write_cascade_in(write_cascade_in),
    .read_cascade_in(read_cascade_in),
    .write_cascade_out(write_cascade_out),
    .read_cascade_out(read_cascade_out));

  dcf_partner p (.clock(clock), .arst_n(arst_n), .writeEn_n(writeEn_n),
    .dataIn(dataIn), .offset_load_n(offset_load_n), .readEn_n(readEn_n));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic print_verdict();
    fail_count += p.waitFails;
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [17:0] got, input logic [17:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic idle();
    @(posedge clock);
    #1;
  endtask

  // one settling edge first, so sync-mode almost flags catch up
  task automatic chkf(input logic [4:0] e);
    idle();
    chk({13'h0000, flags}, {13'h0000, e}, "flags");
  endtask

  task automatic rd(input logic [17:0] e);
    p.get(1'b1);
    idle();
    chk(dataOut, e, "read word");
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    repeat (16) @(posedge clock);
    #1;
    arst_n = 1'b1;
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_reset();
    chkf(5'h0D);
    chk(dataOut, 18'h00000, "output after reset");
    chk({17'h00000, dataOutEn}, 18'h00001, "drive after reset");
  endtask

  task automatic t_offsets();
    p.get(1'b0);
    chk(dataOut, {2'h0, dcf_pkg::EMPTY_OFS_RST}, "empty default");
    idle();
    p.get(1'b0);
    chk(dataOut, {2'h0, dcf_pkg::FULL_OFS_RST}, "full default");
    idle();
    p.put(18'h00009, 2, 1'b0);
    idle();
    p.put(18'h00002, 1, 1'b0);
    idle();
    p.put(18'h00003, 1, 1'b0);
    idle();
    p.get(1'b0);
    chk(dataOut, 18'h00002, "empty offset");
    idle();
    p.get(1'b0);
    chk(dataOut, 18'h00003, "full offset");
  endtask

  // offsets now n=2 and m=3
  task automatic t_fill();
    idle();
    p.put(18'h00000, 2, 1'b1);
    chkf(5'h1D);
    p.put(18'h00002, 1, 1'b1);
    chkf(5'h1F);
    p.put(18'h00003, HALF - 3, 1'b1);
    chkf(5'h1F);
    p.put(18'(HALF), 1, 1'b1);
    chkf(5'h1B);
    p.put(18'(HALF + 1), DEPTH - HALF - 5, 1'b1);
    chkf(5'h1B);
    p.put(18'(DEPTH - 4), 1, 1'b1);
    chkf(5'h1A);
    p.put(18'(DEPTH - 3), 3, 1'b1);
    chkf(5'h12);
    p.put(18'h3FFFF, 1, 1'b1);
    chkf(5'h12);
    for (int i = 0; i < DEPTH; i++) begin
      rd(18'(i));
    end
    chkf(5'h0D);
    rd(18'(DEPTH - 1));
  endtask

  task automatic t_oe();
    outEnable_n = 1'b1;
    idle();
    chk({17'h00000, dataOutEn}, 18'h00000, "released");
    outEnable_n = 1'b0;
    idle();
    chk({17'h00000, dataOutEn}, 18'h00001, "driving");
  endtask

  task automatic t_replay();
    p.put(18'h00100, 4, 1'b1);
    idle();
    rd(18'h00100);
    rd(18'h00101);
    replay_pulse = 1'b1;
    idle();
    replay_pulse = 1'b0;
    idle();
    for (int i = 0; i < 4; i++) begin
      rd(18'h00100 + 18'(i));
    end
    chkf(5'h0D);
  endtask

  // empty offset 1: two words sit just above the almost-empty point
  task automatic t_mode();
    p.put(18'h00001, 1, 1'b0);
    idle();
    p.put(18'h00500, 2, 1'b1);
    chk({13'h0000, flags}, {13'h0000, 5'h1D}, "sync lag");
    chkf(5'h1F);
    // async flags follow the post-edge count, no lag
    sync_flag_mode = 1'b1;
    p.get(1'b1);
    chk({13'h0000, flags}, {13'h0000, 5'h1D}, "async flags");
    idle();
    chk(dataOut, 18'h00500, "async read word");
    sync_flag_mode = 1'b0;
  endtask

  // first device passes both tokens after the last location, then waits
  task automatic t_cascade();
    depthExpand = 1'b1;
    first_load_n = 1'b0;
    do_reset();
    idle();
    chk({17'h00000, dataOutEn}, 18'h00000, "token unresolved");
    p.put(18'h00000, DEPTH, 1'b1);
    chk({17'h00000, write_cascade_out}, 18'h00000, "wr token out");
    chkf(5'h12);
    chk({17'h00000, write_cascade_out}, 18'h00001, "wr pulse end");
    p.drain(DEPTH);
    chk({17'h00000, read_cascade_out}, 18'h00000, "rd token out");
    idle();
    chk({17'h00000, read_cascade_out}, 18'h00001, "rd pulse end");
    chk(dataOut, 18'(DEPTH - 1), "last cascade word");
    chk({17'h00000, dataOutEn}, 18'h00000, "rd token gone");
    p.put(18'h00300, 1, 1'b1);
    chkf(5'h0D);
    write_cascade_in = 1'b0;
    idle();
    write_cascade_in = 1'b1;
    p.put(18'h00300, 2, 1'b1);
    chkf(5'h1D);
    rd(18'(DEPTH - 1));
    read_cascade_in = 1'b0;
    idle();
    read_cascade_in = 1'b1;
    idle();
    chk({17'h00000, dataOutEn}, 18'h00001, "rd token back");
    rd(18'h00300);
    rd(18'h00301);
    // a later device starts without either token
    first_load_n = 1'b1;
    do_reset();
    idle();
    p.put(18'h00400, 1, 1'b1);
    chkf(5'h0D);
    chk({17'h00000, dataOutEn}, 18'h00000, "not first device");
  endtask

  initial begin
    arst_n = 1'b0;
    outEnable_n = 1'b0;
    replay_pulse = 1'b0;
    sync_flag_mode = 1'b0;
    depthExpand = 1'b0;
    first_load_n = 1'b0;
    write_cascade_in = 1'b1;
    read_cascade_in = 1'b1;
    do_reset();
    t_reset();
    t_offsets();
    t_fill();
    t_oe();
    do_reset();
    t_replay();
    t_mode();
    t_cascade();
    print_verdict();
  end

  // hang guard, well past the longest sequence
  initial begin
    #240000;
    fail_count++;
    print_verdict();
  end
endmodule
